// [hdl/bca_bus_control.sv]
// Bus control: byte lanes, bus sizing, mastership, wait states and refresh
`timescale 1ns/1ps
`include "bca_params.svh"
module bca_bus_control
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cpu_req_i,
   input wire logic cpu_lock_i,
   input wire logic [`BCA_ADDR_W-1:0] cpu_addr_i,
   input wire logic cpu_io_i,
   input wire logic cpu_write_i,
   input wire logic cpu_width16_i,
   input wire logic [`BCA_DATA_W-1:0] cpu_wdata_i,
   output logic cpu_done_o,
   output logic [`BCA_DATA_W-1:0] rdata_o,
   input wire logic dma_req_i,
   input wire logic [`BCA_ADDR_W-1:0] dma_addr_i,
   input wire logic dma_write_i,
   input wire logic dma_width16_i,
   output logic dma_done_o,
   input wire logic ref_req_i,
   input wire logic ref_urgent_i,
   output logic ref_done_o,
   input wire logic [`BCA_FIELD_W-1:0] blk_bound_lo_i,
   input wire logic [`BCA_FIELD_W-1:0] blk_bound_hi_i,
   input wire logic [`BCA_WAIT_W-1:0] blk_wait0_i,
   input wire logic [`BCA_WAIT_W-1:0] blk_wait1_i,
   input wire logic [`BCA_WAIT_W-1:0] blk_wait2_i,
   input wire logic [`BCA_FIELD_W-1:0] sub_region_i,
   input wire logic [`BCA_FIELD_W-1:0] sub_bound_lo_i,
   input wire logic [`BCA_FIELD_W-1:0] sub_bound_hi_i,
   input wire logic [`BCA_WAIT_W-1:0] sub_wait0_i,
   input wire logic [`BCA_WAIT_W-1:0] sub_wait1_i,
   input wire logic [`BCA_WAIT_W-1:0] sub_wait2_i,
   input wire logic [`BCA_WAIT_W-1:0] io_wait_i,
   input wire logic [`BCA_WAIT_W-1:0] ref_wait_i,
   input wire logic hold_request_i,
   output logic hold_acknowledge_o,
   output logic bus_lock_n_o,
   input wire logic ready_n_i,
   input wire logic bus8_i,
   output logic [`BCA_ADDR_W-1:0] addr_o,
   output logic addr_bit_zero_o,
   output logic upper_byte_enable_n_o,
   output logic addr_oe_o,
   input wire logic [`BCA_DATA_W-1:0] data_i,
   output logic [`BCA_DATA_W-1:0] data_o,
   output logic data_oe_o,
   output logic read_n_o,
   output logic write_n_o,
   output logic mem_io_o,
   output logic refresh_cycle_indicator_n_o
);
   import bca_pkg::*;
   //------------------------------------------------------------
   // State and wait selection
   //------------------------------------------------------------
   bca_regs_t r;
   bca_regs_t next_r;
   logic [`BCA_WAIT_W-1:0] blk_wait;
   logic [`BCA_WAIT_W-1:0] sub_wait;
   logic cycle_end;
   logic go_split;

   // Whole 16 megabytes split into three blocks, looked up on the latched address
   bca_wait_block #(.FW(`BCA_FIELD_W), .WW(`BCA_WAIT_W)) u_blk_wait
   (
      .field_i(r.addr[`BCA_BLK_HI:`BCA_BLK_LO]),
      .bound_lo_i(blk_bound_lo_i),
      .bound_hi_i(blk_bound_hi_i),
      .wait0_i(blk_wait0_i),
      .wait1_i(blk_wait1_i),
      .wait2_i(blk_wait2_i),
      .wait_o(blk_wait)
   );
   // Chosen megabyte split into three blocks of its own
   bca_wait_block #(.FW(`BCA_FIELD_W), .WW(`BCA_WAIT_W)) u_sub_wait
   (
      .field_i(r.addr[`BCA_SUB_HI:`BCA_SUB_LO]),
      .bound_lo_i(sub_bound_lo_i),
      .bound_hi_i(sub_bound_hi_i),
      .wait0_i(sub_wait0_i),
      .wait1_i(sub_wait1_i),
      .wait2_i(sub_wait2_i),
      .wait_o(sub_wait)
   );

   // Cycle ends once programmed waits are spent and ready is seen low
   assign cycle_end = (r.state == ST_DATA) && (r.wcnt == `BCA_WAIT_ZERO)
                      && !r.rdy_s2;
   // A full-width CPU or DMA memory access to a byte-wide device needs a second cycle
   assign go_split = cycle_end && !r.split && r.b8_s2 && !r.ube_n && !r.a0
                     && !r.io && (r.owner != OWN_REF);

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      // Two-flop synchronisers on pin inputs
      next_r.hold_s1 = hold_request_i;
      next_r.hold_s2 = r.hold_s1;
      next_r.rdy_s1 = ready_n_i;
      next_r.rdy_s2 = r.rdy_s1;
      next_r.b8_s1 = bus8_i;
      next_r.b8_s2 = r.b8_s1;
      next_r.din_s1 = data_i;
      next_r.din_s2 = r.din_s1;
      // Pin data reach the second flop two cycles after the strobe, so capture waits
      next_r.cap_lo = {r.cap_lo[`BCA_CAP_W-2:0], go_split && !r.wr};
      next_r.cap_rd = {r.cap_rd[`BCA_CAP_W-2:0], cpu_done_o && !r.wr};
      if (cycle_end)
         next_r.cap_join = r.split;
      if (r.cap_lo[`BCA_CAP_W-1])
         next_r.lo_byte = r.din_s2[`BCA_LO_BYTE_HI:0];
      if (r.cap_rd[`BCA_CAP_W-1])
         next_r.rdata = r.cap_join ? {r.din_s2[`BCA_LO_BYTE_HI:0], r.lo_byte} : r.din_s2;
      unique case (r.state)
         ST_IDLE:
         begin
            // Arbitration only happens between bus cycles
            if (!cpu_lock_i)
               next_r.locked = 1'b0;
            if (cpu_req_i && cpu_lock_i)
            begin
               next_r.owner = OWN_CPU;
               next_r.locked = 1'b1;
               next_r.state = ST_T1;
            end
            else if (ref_urgent_i)
            begin
               next_r.owner = OWN_REF;
               next_r.state = ST_T1;
            end
            else if (dma_req_i)
            begin
               next_r.owner = OWN_DMA;
               next_r.state = ST_T1;
            end
            else if (r.hold_s2 && !r.locked)
               next_r.state = ST_HOLD;
            else if (cpu_req_i)
            begin
               next_r.owner = OWN_CPU;
               next_r.state = ST_T1;
            end
            else if (ref_req_i)
            begin
               next_r.owner = OWN_REF;
               next_r.state = ST_T1;
            end
            // Latch the winner's cycle description
            next_r.split = 1'b0;
            if (next_r.state == ST_T1)
            begin
               unique case (next_r.owner)
                  OWN_CPU:
                  begin
                     next_r.addr = cpu_addr_i;
                     next_r.wr = cpu_write_i;
                     next_r.io = cpu_io_i;
                     next_r.wdata = cpu_wdata_i;
                     next_r.a0 = cpu_addr_i[0];
                     next_r.ube_n = !(cpu_width16_i || cpu_addr_i[0]);
                  end
                  OWN_DMA:
                  begin
                     next_r.addr = dma_addr_i;
                     next_r.wr = dma_write_i;
                     next_r.io = 1'b0;
                     next_r.a0 = dma_addr_i[0];
                     next_r.ube_n = !(dma_width16_i || dma_addr_i[0]);
                  end
                  OWN_REF:
                  begin
                     next_r.addr = {`BCA_REF_PAD, r.ref_addr};
                     next_r.wr = 1'b0;
                     next_r.io = 1'b0;
                     next_r.a0 = r.ref_addr[0];
                     next_r.ube_n = 1'b0;
                  end
               endcase
            end
         end
         ST_T1:
         begin
            // Load the programmed wait count for this cycle
            if (r.owner == OWN_REF)
               next_r.wcnt = ref_wait_i;
            else if (r.io)
               next_r.wcnt = io_wait_i;
            else if (r.addr[`BCA_BLK_HI:`BCA_BLK_LO] == sub_region_i)
               next_r.wcnt = sub_wait;
            else
               next_r.wcnt = blk_wait;
            next_r.state = ST_DATA;
         end
         ST_DATA:
         begin
            if (r.wcnt != `BCA_WAIT_ZERO)
               next_r.wcnt = r.wcnt - `BCA_WAIT_ONE;
            else if (go_split)
            begin
               // Second cycle: upper byte moves onto the lower lane
               next_r.wdata = {2{r.wdata[`BCA_HI_BYTE_HI:`BCA_HI_BYTE_LO]}};
               next_r.ube_n = 1'b1;
               next_r.a0 = 1'b1;
               next_r.split = 1'b1;
               next_r.state = ST_T1;
            end
            else if (cycle_end)
            begin
               if (r.owner == OWN_REF)
                  next_r.ref_addr = r.ref_addr + `BCA_REF_ONE;
               next_r.state = ST_IDLE;
            end
         end
         ST_HOLD:
         begin
            if (ref_urgent_i || dma_req_i)
               next_r.state = ST_HDROP;
            else if (!r.hold_s2)
               next_r.state = ST_IDLE;
         end
         ST_HDROP:
         begin
            // Bus stays released until the external master lets go
            if (!r.hold_s2)
               next_r.state = ST_IDLE;
         end
      endcase
   end
   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         r <= '0;
         r.state <= ST_IDLE;
         r.owner <= OWN_CPU;
         r.ube_n <= 1'b1;
         r.rdy_s1 <= 1'b1;
         r.rdy_s2 <= 1'b1;
         r.ref_addr <= `BCA_REF_RST;
      end
      else
      begin
         r <= next_r;
      end
   end

   //------------------------------------------------------------
   // Pin and handshake outputs
   //------------------------------------------------------------
   // Completion pulses in the cycle the bus cycle ends
   assign cpu_done_o = cycle_end && !go_split && (r.owner == OWN_CPU);
   assign dma_done_o = cycle_end && !go_split && (r.owner == OWN_DMA);
   assign ref_done_o = cycle_end && (r.owner == OWN_REF);
   assign rdata_o = r.rdata;

   // One shared interface drives address and strobes for every internal master, data only for CPU writes
   assign addr_o = r.addr;
   assign addr_bit_zero_o = r.a0;
   assign upper_byte_enable_n_o = r.ube_n;
   assign data_o = r.wdata;
   assign addr_oe_o = !((r.state == ST_HOLD) || (r.state == ST_HDROP));
   assign data_oe_o = r.wr && (r.owner == OWN_CPU)
                      && ((r.state == ST_T1) || (r.state == ST_DATA));
   assign read_n_o = !((r.state == ST_DATA) && !r.wr);
   assign write_n_o = !((r.state == ST_DATA) && r.wr);
   assign mem_io_o = !r.io;
   assign refresh_cycle_indicator_n_o = !((r.owner == OWN_REF)
      && ((r.state == ST_T1) || (r.state == ST_DATA)));
   assign hold_acknowledge_o = (r.state == ST_HOLD);
   assign bus_lock_n_o = !r.locked;
endmodule

// [hdl/bca_wait_block.sv]
// Three-block wait count selector for one address field
`timescale 1ns/1ps
module bca_wait_block
#(
   parameter int FW = 4,
   parameter int WW = 3
)
(
   input wire logic [FW-1:0] field_i,
   input wire logic [FW-1:0] bound_lo_i,
   input wire logic [FW-1:0] bound_hi_i,
   input wire logic [WW-1:0] wait0_i,
   input wire logic [WW-1:0] wait1_i,
   input wire logic [WW-1:0] wait2_i,
   output logic [WW-1:0] wait_o
);
   // Below the low bound is block 0, below the high bound block 1, else block 2
   always_comb
   begin
      if (field_i < bound_lo_i)
      begin
         wait_o = wait0_i;
      end
      else if (field_i < bound_hi_i)
      begin
         wait_o = wait1_i;
      end
      else
      begin
         wait_o = wait2_i;
      end
   end
endmodule

// [include/bca_params.svh]
// Widths, field positions and reset values of the bus control block
`ifndef BCA_PARAMS_SVH
`define BCA_PARAMS_SVH

`define BCA_ADDR_W 24
`define BCA_DATA_W 16
`define BCA_BYTE_W 8
`define BCA_REF_W 16
`define BCA_WAIT_W 3
`define BCA_FIELD_W 4
`define BCA_BLK_HI 23
`define BCA_BLK_LO 20
`define BCA_SUB_HI 19
`define BCA_SUB_LO 16
`define BCA_HI_BYTE_HI 15
`define BCA_HI_BYTE_LO 8
`define BCA_LO_BYTE_HI 7
`define BCA_WAIT_ZERO 3'h0
`define BCA_WAIT_ONE 3'h1
`define BCA_REF_RST 16'h0000
`define BCA_REF_ONE 16'h0001
`define BCA_REF_PAD 8'h00
`define BCA_CAP_W 2

`endif

// [include/bca_pkg.sv]
// Types shared by the bus control block
package bca_pkg;
`include "bca_params.svh"

   // Bus sequencer states
   typedef enum logic [4:0]
   {
      ST_IDLE  = 5'b00001,
      ST_T1    = 5'b00010,
      ST_DATA  = 5'b00100,
      ST_HOLD  = 5'b01000,
      ST_HDROP = 5'b10000
   } bca_state_t;

   // Internal bus owners
   typedef enum logic [2:0]
   {
      OWN_CPU = 3'b001,
      OWN_DMA = 3'b010,
      OWN_REF = 3'b100
   } bca_owner_t;

   // Complete register state of the top module
   typedef struct packed
   {
      bca_state_t state;
      bca_owner_t owner;
      logic locked;
      logic [`BCA_ADDR_W-1:0] addr;
      logic wr;
      logic io;
      logic ube_n;
      logic a0;
      logic split;
      logic [`BCA_WAIT_W-1:0] wcnt;
      logic [`BCA_DATA_W-1:0] wdata;
      logic [`BCA_BYTE_W-1:0] lo_byte;
      logic [`BCA_DATA_W-1:0] rdata;
      logic [`BCA_REF_W-1:0] ref_addr;
      logic hold_s1;
      logic hold_s2;
      logic rdy_s1;
      logic rdy_s2;
      logic b8_s1;
      logic b8_s2;
      logic [`BCA_DATA_W-1:0] din_s1;
      logic [`BCA_DATA_W-1:0] din_s2;
      logic [`BCA_CAP_W-1:0] cap_lo;
      logic [`BCA_CAP_W-1:0] cap_rd;
      logic cap_join;
   } bca_regs_t;
endpackage

// [test/bca_ext_mem.sv]
// External memory and I/O model on the far side of the bus
`timescale 1ns/1ps
module bca_ext_mem
(
   input wire logic clk_i,
   input wire logic read_n_i,
   input wire logic write_n_i,
   input wire logic addr_oe_i,
   input wire logic [23:0] addr_i,
   input wire logic addr_bit_zero_i,
   input wire logic byte_dev_i,
   input wire logic [3:0] slow_i,
   output logic [15:0] data_o,
   output logic ready_n_o,
   output logic bus8_o
);
   logic [3:0] cnt = 4'h0;
   logic [15:0] last = 16'h0000;
   logic [7:0] b;
   logic idle;
   // Byte device takes bit zero as an ordinary address bit
   assign b = {addr_i[7:1], addr_bit_zero_i} ^ 8'h5A;
   assign idle = read_n_i & write_n_i;
   assign bus8_o = byte_dev_i;
   // Ready held off slow_i cycles; pulled high when idle in slow mode
   assign ready_n_o = idle ? (slow_i != 4'h0) : (cnt != 4'h0);
   // Released lanes show a changing pattern
   always_comb
   begin
      if (read_n_i || !addr_oe_i)
         data_o = ~last;
      else if (byte_dev_i)
         data_o = {~last[15:8], b};
      else
         data_o = {{addr_i[7:1], 1'b1} ^ 8'h5A, {addr_i[7:1], 1'b0} ^ 8'h5A};
   end
   // Wait counter and last lane value
   always_ff @(posedge clk_i)
   begin
      cnt <= idle ? slow_i : cnt - {3'h0, cnt != 4'h0};
      last <= data_o;
   end
endmodule

// [test/bca_sva.sv]
// Checker for the bus control block
`timescale 1ns/1ps
`include "bca_params.svh"
module bca_sva
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cpu_done_o,
   input wire logic ref_done_o,
   input wire logic dma_req_i,
   input wire logic ref_urgent_i,
   input wire logic hold_request_i,
   input wire logic hold_acknowledge_o,
   input wire logic bus_lock_n_o,
   input wire logic ready_n_i,
   input wire logic [`BCA_ADDR_W-1:0] addr_o,
   input wire logic read_n_o,
   input wire logic write_n_o,
   input wire logic mem_io_o,
   input wire logic [`BCA_WAIT_W-1:0] io_wait_i,
   input wire logic refresh_cycle_indicator_n_o
);
   logic strb;
   logic [7:0] lowcnt;
   logic [15:0] last_ref;
   logic ref_seen;
   assign strb = read_n_o & write_n_o;
   // Strobe length and last refresh address
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         lowcnt <= 8'h00;
         last_ref <= 16'h0000;
         ref_seen <= 1'b0;
      end
      else
      begin
         lowcnt <= strb ? 8'h00 : lowcnt + 8'h01;
         last_ref <= ref_done_o ? addr_o[15:0] : last_ref;
         ref_seen <= ref_seen | ref_done_o;
      end
   end
   //------------------------------------------------------------
   // Properties
   //------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence cyc_on;
      !strb;
   endsequence
   sequence io_end;
      $rose(strb) && !$past(mem_io_o);
   endsequence
   io_wait_a: assert property (io_end |-> lowcnt >= {5'h00, io_wait_i} + 8'h01)
      else $error("I/O cycle shorter than its wait count");
   stable_own_a: assert property (cyc_on ##1 cyc_on |-> $stable(addr_o) && $stable(mem_io_o))
      else $error("address changed inside a bus cycle");
   ready_gate_a: assert property (cpu_done_o |-> !$past(ready_n_i, 2))
      else $error("cycle ended without ready");
   ref_ind_a: assert property (ref_done_o |-> !refresh_cycle_indicator_n_o)
      else $error("refresh ended without indicator");
   ref_step_a: assert property ($fell(refresh_cycle_indicator_n_o) && ref_seen |->
      addr_o == {8'h00, last_ref + 16'h0001})
      else $error("refresh address did not step");
   ack_drop_a: assert property (hold_acknowledge_o && (dma_req_i || ref_urgent_i) |=>
      !hold_acknowledge_o)
      else $error("acknowledge kept during DMA request");
   lock_hold_a: assert property (!bus_lock_n_o |-> !hold_acknowledge_o)
      else $error("hold granted while locked");
   hold_late_a: assert property ($rose(hold_acknowledge_o) |-> $past(hold_request_i, 3))
      else $error("acknowledge without sampled request");
endmodule

bind bca_bus_control bca_sva u_bca_sva (.clk_i, .rst_n_i, .cpu_done_o, .ref_done_o,
   .dma_req_i, .ref_urgent_i, .hold_request_i, .hold_acknowledge_o, .bus_lock_n_o,
   .ready_n_i, .addr_o, .read_n_o, .write_n_o, .mem_io_o, .io_wait_i,
   .refresh_cycle_indicator_n_o);

// [test/tb.sv]
// Self-checking bench for the bus control block
`timescale 1ns/1ps
module tb;
   logic clk_i = 0, rst_n_i = 0, cpu_req_i = 0, cpu_lock_i = 0, cpu_io_i = 0;
   logic cpu_write_i = 0, cpu_width16_i = 0, dma_req_i = 0, dma_write_i = 0;
   logic dma_width16_i = 1, ref_req_i = 0, ref_urgent_i = 0, hold_request_i = 0, byte_dev = 0;
   logic [23:0] cpu_addr_i = 24'h0, dma_addr_i = 24'h000300, addr_o, ra1, ra2;
   logic [15:0] cpu_wdata_i = 16'hC3A5, rdata_o, data_i, data_o;
   logic [3:0] blk_bound_lo_i = 4'h4, blk_bound_hi_i = 4'h8, sub_region_i = 4'h0;
   logic [3:0] sub_bound_lo_i = 4'h4, sub_bound_hi_i = 4'h8, slow = 4'h0;
   logic [2:0] blk_wait0_i = 3'h0, blk_wait1_i = 3'h2, blk_wait2_i = 3'h3, io_wait_i = 3'h3;
   logic [2:0] sub_wait0_i = 3'h4, sub_wait1_i = 3'h5, sub_wait2_i = 3'h6, ref_wait_i = 3'h1;
   logic cpu_done_o, dma_done_o, ref_done_o, hold_acknowledge_o, bus_lock_n_o, addr_oe_o;
   logic addr_bit_zero_o, upper_byte_enable_n_o, data_oe_o, read_n_o, write_n_o, mem_io_o;
   logic refresh_cycle_indicator_n_o, ready_n_i, bus8_i, pl = 0, pr = 0;
   logic [1:0] fl, ll;
   logic [16:0] wd;
   logic [23:0] wa[5] = '{24'h200000, 24'h400000, 24'h800000, 24'h0A0000, 24'h000040};
   logic [2:0] ww[5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h3};
   int n_errors = 0, n_compared = 0, nf = 0, cur = 0, len = 0, cyc = 0;
   bca_bus_control u_bca_bus_control (.clk_i, .rst_n_i, .cpu_req_i, .cpu_lock_i,
      .cpu_addr_i, .cpu_io_i, .cpu_write_i, .cpu_width16_i, .cpu_wdata_i, .cpu_done_o,
      .rdata_o, .dma_req_i, .dma_addr_i, .dma_write_i, .dma_width16_i, .dma_done_o,
      .ref_req_i, .ref_urgent_i, .ref_done_o, .blk_bound_lo_i, .blk_bound_hi_i,
      .blk_wait0_i, .blk_wait1_i, .blk_wait2_i, .sub_region_i, .sub_bound_lo_i,
      .sub_bound_hi_i, .sub_wait0_i, .sub_wait1_i, .sub_wait2_i, .io_wait_i, .ref_wait_i,
      .hold_request_i, .hold_acknowledge_o, .bus_lock_n_o, .ready_n_i, .bus8_i, .addr_o,
      .addr_bit_zero_o, .upper_byte_enable_n_o, .addr_oe_o, .data_i, .data_o, .data_oe_o,
      .read_n_o, .write_n_o, .mem_io_o, .refresh_cycle_indicator_n_o);
   bca_ext_mem u_bca_ext_mem (.clk_i, .read_n_i(read_n_o), .write_n_i(write_n_o),
      .addr_oe_i(addr_oe_o), .addr_i(addr_o), .addr_bit_zero_i(addr_bit_zero_o),
      .byte_dev_i(byte_dev), .slow_i(slow), .data_o(data_i), .ready_n_o(ready_n_i),
      .bus8_o(bus8_i));
   // Clock and cycle ceiling
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         summarize;
      end
   end
   // Lanes at each strobe start, strobe length, refresh addresses
   always @(negedge clk_i)
   begin
      if (!pr && refresh_cycle_indicator_n_o === 1'b0)
      begin
         ra1 = ra2;
         ra2 = addr_o;
      end
      pr = (refresh_cycle_indicator_n_o === 1'b0);
      if (write_n_o === 1'b0)
         wd = {data_oe_o, data_o};
      if ((read_n_o & write_n_o) === 1'b0)
      begin
         if (!pl)
            fl = (nf == 0) ? {upper_byte_enable_n_o, addr_bit_zero_o} : fl;
         if (!pl)
            ll = {upper_byte_enable_n_o, addr_bit_zero_o};
         nf += !pl;
         cur++;
         pl = 1;
      end
      else
      begin
         len = pl ? cur : len;
         cur = 0;
         pl = 0;
      end
   end
   //------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------
   task chk(input string n, input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", n, exp, got);
      end
   endtask
   task summarize;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task cpu(input logic [23:0] a, input logic w16, input logic io);
      int k;
      @(posedge clk_i);
      nf = 0;
      cpu_addr_i <= a;
      cpu_width16_i <= w16;
      cpu_io_i <= io;
      cpu_req_i <= 1'b1;
      for (k = 0; k < 200 && cpu_done_o !== 1'b1; k++)
         @(negedge clk_i);
      @(posedge clk_i);
      cpu_req_i <= 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   task t_write;
      @(posedge clk_i);
      cpu_write_i <= 1'b1;
      cpu(24'h000100, 1, 0);
      chk("write data", wd, 17'h1C3A5);
      chk("write lanes", fl, 2'h0);
      @(posedge clk_i);
      cpu_write_i <= 1'b0;
   endtask
   task t_lanes;
      cpu(24'h000102, 0, 0);
      chk("lower lane", fl, 2'h2);
      cpu(24'h000103, 0, 0);
      chk("upper lane", fl, 2'h1);
      cpu(24'h000100, 1, 0);
      chk("word lanes", fl, 2'h0);
      chk("one cycle", nf, 1);
      chk("word data", rdata_o, 16'h5B5A);
   endtask
   task t_size;
      @(posedge clk_i);
      byte_dev <= 1'b1;
      cpu(24'h000200, 1, 0);
      chk("split first", fl, 2'h0);
      chk("split second", ll, 2'h3);
      chk("split count", nf, 2);
      chk("split data", rdata_o, 16'h5B5A);
      byte_dev <= 1'b0;
   endtask
   task t_wait;
      for (int i = 0; i < 5; i++)
      begin
         cpu(wa[i], 1, i == 4);
         chk("wait length", 24'(len), 24'(ww[i]) + 24'h1);
         chk("wait data", rdata_o, (i == 4) ? 16'h1B1A : 16'h5B5A);
      end
      slow <= 4'h5;
      cpu(24'h000040, 0, 1);
      chk("ready stretch", len > 6, 1);
      slow <= 4'h0;
   endtask
   task race(input logic c, d, u, r, l, input logic [5:0] exp);
      logic [5:0] ord;
      ord = 6'h00;
      for (int k = 0; k < 300; k++)
      begin
         @(posedge clk_i);
         cpu_req_i <= c;
         cpu_lock_i <= c & l;
         dma_req_i <= d;
         ref_urgent_i <= u;
         ref_req_i <= r;
         @(negedge clk_i);
         if (c && cpu_done_o === 1'b1)
            ord = {ord[3:0], 2'h1};
         if (d && dma_done_o === 1'b1)
            ord = {ord[3:0], 2'h2};
         if ((u || r) && ref_done_o === 1'b1)
            ord = {ord[3:0], 2'h3};
         c = c && cpu_done_o !== 1'b1;
         d = d && dma_done_o !== 1'b1;
         u = u && ref_done_o !== 1'b1;
         r = r && ref_done_o !== 1'b1;
      end
      chk("grant order", ord, exp);
   endtask
   task t_hold;
      @(posedge clk_i);
      hold_request_i <= 1'b1;
      for (int k = 0; k < 10 && hold_acknowledge_o !== 1'b1; k++)
         @(negedge clk_i);
      chk("hold ack", hold_acknowledge_o, 1);
      chk("bus float", addr_oe_o, 0);
      @(posedge clk_i);
      dma_req_i <= 1'b1;
      @(negedge clk_i);
      @(negedge clk_i);
      chk("ack drop", hold_acknowledge_o, 0);
      @(posedge clk_i);
      hold_request_i <= 1'b0;
      for (int k = 0; k < 20 && dma_done_o !== 1'b1; k++)
         @(negedge clk_i);
      chk("dma after hold", dma_done_o, 1);
      @(posedge clk_i);
      dma_req_i <= 1'b0;
   endtask
   task t_ref;
      for (int j = 0; j < 2; j++)
      begin
         @(posedge clk_i);
         ref_req_i <= 1'b1;
         for (int k = 0; k < 30 && ref_done_o !== 1'b1; k++)
            @(negedge clk_i);
         @(posedge clk_i);
         ref_req_i <= 1'b0;
      end
      chk("refresh step", ra2, {8'h00, ra1[15:0] + 16'h0001});
   endtask
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_lanes;
      t_write;
      t_size;
      t_wait;
      race(1, 1, 1, 0, 0, 6'h39);
      race(1, 0, 0, 1, 0, 6'h07);
      race(1, 1, 1, 0, 1, 6'h1E);
      t_hold;
      t_ref;
      summarize;
   end
endmodule
